// file: pkg/wdg_regs.svh
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

// ==========================================================================
// Register byte offsets on the APB port.
`define WDG_OFS_CTRL      8'h00
`define WDG_OFS_FLAGS     8'h04
`define WDG_OFS_STATUS    8'h08
`define WDG_OFS_IRQ_STAT  8'h0C
`define WDG_OFS_IRQ_MASK  8'h10
`define WDG_OFS_PIN_CTRL  8'h14
`define WDG_OFS_COUNT     8'h18

// ==========================================================================
// Field positions.
`define WDG_KEY_MSB       7
`define WDG_KEY_LSB       3
`define WDG_SEL_MSB       2
`define WDG_SEL_LSB       0
`define WDG_FLAG_KEY_BIT  0
`define WDG_ST_TO_BIT     0
`define WDG_ST_PDF_BIT    1
`define WDG_ST_EN_BIT     2
`define WDG_ST_WAIT_BIT   3
`define WDG_IRQ_OVF_BIT   0
`define WDG_IRQ_KEY_BIT   1
`define WDG_IRQ_PIN_BIT   2

// ==========================================================================
// Reset values and codes.
`define WDG_CTRL_RST      8'h53
`define WDG_PIN_CTRL_RST  8'h55
`define WDG_PIN_SEL_RESET 8'hAA
`define WDG_KEY_ENABLE    5'h0A
`define WDG_KEY_DISABLE   5'h15
`define WDG_IRQ_RST       3'h0

// ==========================================================================
// Timing: system clock period and the key reset delay, both in ns.
`define WDG_CLK_NS        50
`define WDG_SRESET_NS     100000
`define WDG_SRESET_CYC    ((`WDG_SRESET_NS + `WDG_CLK_NS - 1) / `WDG_CLK_NS)

`endif

// file: pkg/wdg_pkg.sv
package wdg_pkg;

  // ========================================================================
  // Key supervision states, one-hot.
  typedef enum logic [1:0] {
    WDG_KS_RUN  = 2'b01,
    WDG_KS_WAIT = 2'b10
  } wdg_key_st_e;

  typedef logic [7:0] wdg_byte_t;

endpackage

// file: verilog/wdg_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser; the first stage feeds only the second.
module wdg_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta_r;

  // ========================================================================
  // Synchroniser stages.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// file: verilog/wdg_delay.sv
`timescale 1ns/1ps

// One-shot delay: a start pulse gives a done pulse CYC+1 cycles later.
module wdg_delay #(
  parameter int CYC = 2000,
  parameter int W   = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [W-1:0] cnt_r;

  // Refuse counts the counter cannot hold.
  if (CYC < 1 || CYC >= (1 << W)) begin : g_bad_cyc
    $error("wdg_delay: CYC does not fit W");
  end

  // ========================================================================
  // Down counter; a start while busy is ignored so the delay is never stretched.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (busy) begin
        if (cnt_r == W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_r <= cnt_r - W'(1);
      end else if (start) begin
        busy  <= 1'b1;
        cnt_r <= W'(CYC);
      end
    end
  end

endmodule

// file: verilog/wdg_top.sv
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "wdg_regs.svh"

module wdg_top
  import wdg_pkg::*;
#(
  parameter int CNT_W      = 18,
  parameter int SRESET_CYC = `WDG_SRESET_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_internal_osc,
  input  wire logic        external_reset_pin_n,
  input  wire logic        clear_watchdog_instr,
  input  wire logic        halt_instr,
  input  wire logic        low_power_mode,
  output logic             dev_reset,
  output logic             pc_sp_reset,
  output logic             pc_clear,
  output logic             port_preset,
  output logic             irq
);

  // Refuse counter widths that cannot reach the longest period.
  if (CNT_W < 18) begin : g_bad_cnt_w
    $error("wdg_top: CNT_W must be at least 18");
  end
  if (SRESET_CYC < 1) begin : g_bad_sreset
    $error("wdg_top: SRESET_CYC must be at least 1");
  end

  wdg_byte_t      ctrl_r;
  wdg_byte_t      pin_ctrl_r;
  logic           key_flag_r;
  logic           to_flag_r;
  logic           pdf_flag_r;
  logic [2:0]     irq_stat_r;
  logic [2:0]     irq_mask_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] ovf_mask;
  wdg_key_st_e    key_st_r;
  logic           osc_s;
  logic           osc_d_r;
  logic           pin_s;
  logic           tick;
  logic           wd_en;
  logic           key_bad;
  logic           key_start;
  logic           key_busy;
  logic           key_fire;
  logic           pin_rst;
  logic           ovf;
  logic           cnt_clr;
  logic [4:0]     key;
  logic [2:0]     sel;
  logic           wr_en;
  logic           setup_rd;
  logic           addr_err;
  logic [31:0]    rd_mux;
  logic           err_r;

  // ==========================================================================
  // Pin inputs: oscillator and reset pin cross in through two flops each.
  wdg_sync #(.RST_VAL(1'b0)) u_osc_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (slow_internal_osc),
    .q     (osc_s)
  );

  wdg_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (external_reset_pin_n),
    .q     (pin_s)
  );

  // Rising-edge detect on the synchronised oscillator; the system clock must be
  // far faster than the oscillator, which holds easily at 20 MHz against 32 kHz.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_d_r <= 1'b0;
    end else begin
      osc_d_r <= osc_s;
    end
  end

  assign tick = osc_s & ~osc_d_r;

  // ==========================================================================
  // Key decode and pin selection.
  assign key     = ctrl_r[`WDG_KEY_MSB:`WDG_KEY_LSB];
  assign sel     = ctrl_r[`WDG_SEL_MSB:`WDG_SEL_LSB];
  assign wd_en   = (key == `WDG_KEY_ENABLE);
  assign key_bad = (key != `WDG_KEY_ENABLE) && (key != `WDG_KEY_DISABLE);
  assign pin_rst = (pin_ctrl_r == `WDG_PIN_SEL_RESET) & ~pin_s;

  // Overflow threshold: all bits below the selected period set.
  always_comb begin
    case (sel)
      3'h0:    ovf_mask = CNT_W'({8{1'b1}});
      3'h1:    ovf_mask = CNT_W'({10{1'b1}});
      3'h2:    ovf_mask = CNT_W'({12{1'b1}});
      3'h3:    ovf_mask = CNT_W'({14{1'b1}});
      3'h4:    ovf_mask = CNT_W'({15{1'b1}});
      3'h5:    ovf_mask = CNT_W'({16{1'b1}});
      3'h6:    ovf_mask = CNT_W'({17{1'b1}});
      default: ovf_mask = CNT_W'({18{1'b1}});
    endcase
  end

  // Overflow fires on the tick that would carry out of the selected bit.
  assign ovf = wd_en & tick & ((cnt_r & ovf_mask) == ovf_mask)
             & ~key_busy & ~pin_rst;

  // ==========================================================================
  // Key supervision: a bad key arms the delay once; the reset follows at its end.
  assign key_start = (key_st_r == WDG_KS_RUN) & key_bad;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_st_r <= WDG_KS_RUN;
    end else begin
      case (key_st_r)
        WDG_KS_RUN:  if (key_bad) key_st_r <= WDG_KS_WAIT;
        WDG_KS_WAIT: if (key_fire) key_st_r <= WDG_KS_RUN;
        default:     key_st_r <= WDG_KS_RUN;
      endcase
    end
  end

  wdg_delay #(.CYC(SRESET_CYC), .W(16)) u_key_delay (
    .clk   (clk),
    .rst_n (rst_n),
    .start (key_start),
    .busy  (key_busy),
    .done  (key_fire)
  );

  // ==========================================================================
  // Watchdog counter.
  // The counter is held clear during the key delay so no overflow races the
  // pending key reset.
  assign cnt_clr = key_busy | key_fire | clear_watchdog_instr | halt_instr
                 | pin_rst | ovf;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (cnt_clr) begin
      cnt_r <= '0;
    end else if (wd_en && tick) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // ==========================================================================
  // APB slave: zero wait states, read data captured in the setup cycle.
  assign wr_en    = psel & penable & pwrite & pstrb[0];
  assign setup_rd = psel & ~penable;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & err_r;

  always_comb begin
    addr_err = 1'b0;
    rd_mux   = 32'h0000_0000;
    if (paddr == `WDG_OFS_CTRL) begin
      rd_mux[7:0] = ctrl_r;
    end else if (paddr == `WDG_OFS_FLAGS) begin
      rd_mux[`WDG_FLAG_KEY_BIT] = key_flag_r;
    end else if (paddr == `WDG_OFS_STATUS) begin
      rd_mux[`WDG_ST_TO_BIT]   = to_flag_r;
      rd_mux[`WDG_ST_PDF_BIT]  = pdf_flag_r;
      rd_mux[`WDG_ST_EN_BIT]   = wd_en;
      rd_mux[`WDG_ST_WAIT_BIT] = key_busy;
    end else if (paddr == `WDG_OFS_IRQ_STAT) begin
      rd_mux[2:0] = irq_stat_r;
    end else if (paddr == `WDG_OFS_IRQ_MASK) begin
      rd_mux[2:0] = irq_mask_r;
    end else if (paddr == `WDG_OFS_PIN_CTRL) begin
      rd_mux[7:0] = pin_ctrl_r;
    end else if (paddr == `WDG_OFS_COUNT) begin
      rd_mux[CNT_W-1:0] = cnt_r;
    end else begin
      addr_err = 1'b1;
    end
  end

  // Read data and error are latched in setup so both come from flops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      err_r  <= 1'b0;
    end else if (setup_rd) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      err_r  <= addr_err;
    end
  end

  // ==========================================================================
  // Control register; the key reset reloads power-on values so it cannot loop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= `WDG_CTRL_RST;
    end else if (key_fire) begin
      ctrl_r <= `WDG_CTRL_RST;
    end else if (wr_en && paddr == `WDG_OFS_CTRL) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // Reset pin selection register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_ctrl_r <= `WDG_PIN_CTRL_RST;
    end else if (wr_en && paddr == `WDG_OFS_PIN_CTRL) begin
      pin_ctrl_r <= pwdata[7:0];
    end
  end

  // Key reset flag: set by hardware, cleared only by writing zero; set wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_flag_r <= 1'b0;
    end else if (key_fire) begin
      key_flag_r <= 1'b1;
    end else if (wr_en && paddr == `WDG_OFS_FLAGS && !pwdata[`WDG_FLAG_KEY_BIT]) begin
      key_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Time-out and power-down flags; an overflow in the same cycle as a clear wins, for the power-down flag only in low-power mode.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      to_flag_r <= 1'b0;
    end else if (ovf) begin
      to_flag_r <= 1'b1;
    end else if (clear_watchdog_instr || halt_instr) begin
      to_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pdf_flag_r <= 1'b0;
    end else if ((ovf && low_power_mode) || halt_instr) begin
      pdf_flag_r <= 1'b1;
    end else if (clear_watchdog_instr) begin
      pdf_flag_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Reset outputs. Power-on holds the PC clear and port preset through reset
  // and one cycle past release.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dev_reset   <= 1'b0;
      pc_sp_reset <= 1'b0;
      pc_clear    <= 1'b1;
      port_preset <= 1'b1;
    end else begin
      dev_reset   <= (ovf & ~low_power_mode) | key_fire | pin_rst;
      pc_sp_reset <= ovf & low_power_mode;
      pc_clear    <= ovf | key_fire | pin_rst;
      port_preset <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt status, write-one-to-clear; a new event beats a clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_r <= `WDG_IRQ_RST;
    end else begin
      if (wr_en && paddr == `WDG_OFS_IRQ_STAT) begin
        irq_stat_r <= irq_stat_r & ~pwdata[2:0];
      end
      if (ovf) irq_stat_r[`WDG_IRQ_OVF_BIT] <= 1'b1;
      if (key_fire) irq_stat_r[`WDG_IRQ_KEY_BIT] <= 1'b1;
      if (pin_rst) irq_stat_r[`WDG_IRQ_PIN_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_r <= `WDG_IRQ_RST;
    end else if (wr_en && paddr == `WDG_OFS_IRQ_MASK) begin
      irq_mask_r <= pwdata[2:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

endmodule

// file: bench/wdg_top_sva.sv
`timescale 1ns/1ps
// ============================================================
// Port-level checks; the counter is internal, so the checks work on the outputs.
module wdg_top_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        slow_internal_osc,
  input wire logic        clear_watchdog_instr,
  input wire logic        halt_instr,
  input wire logic        low_power_mode,
  input wire logic        dev_reset,
  input wire logic        pc_sp_reset,
  input wire logic        pc_clear,
  input wire logic        port_preset,
  input wire logic        pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // The PC clear and port preset hold through reset and drop one edge after release.
  property p_por; $rose(rst_n) |-> port_preset && pc_clear ##1 !port_preset && !pc_clear;
  endproperty
  a_por: assert property (p_por) else $error("reset outputs wrong");
  property p_dev_pc; dev_reset |-> pc_clear; endproperty
  a_dev_pc: assert property (p_dev_pc) else $error("reset without pc clear");
  property p_lp_cause; $rose(pc_sp_reset) |-> $past(low_power_mode) && !dev_reset; endproperty
  a_lp_cause: assert property (p_lp_cause) else $error("partial reset cause");
  property p_lp_pulse; pc_sp_reset |=> !pc_sp_reset; endproperty
  a_lp_pulse: assert property (p_lp_pulse) else $error("partial reset too long");
  // A still oscillator cannot produce an overflow; ticks pass a two-flop sync first.
  property p_osc; $stable(slow_internal_osc) [*8] |-> !pc_sp_reset; endproperty
  a_osc: assert property (p_osc) else $error("overflow without osc");
  // A cleared counter needs at least 256 ticks, far beyond ten cycles.
  property p_clr; clear_watchdog_instr |-> ##2 (!pc_sp_reset) [*8]; endproperty
  a_clr: assert property (p_clr) else $error("overflow after clear");
  property p_halt; halt_instr |=> ##1 (!pc_sp_reset) [*8]; endproperty
  a_halt: assert property (p_halt) else $error("overflow after halt");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
endmodule

bind wdg_top wdg_top_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .slow_internal_osc(slow_internal_osc), .clear_watchdog_instr(clear_watchdog_instr),
  .halt_instr(halt_instr), .low_power_mode(low_power_mode), .dev_reset(dev_reset),
  .pc_sp_reset(pc_sp_reset), .pc_clear(pc_clear), .port_preset(port_preset), .pslverr(pslverr));

// file: bench/wdg_cpu_model.sv
`timescale 1ns/1ps
// ============================================================
// Core stand-in: kicks the watchdog and sleeps on halt until woken by a reset.
module wdg_cpu_model #(
  parameter int KICK_CYC = 400
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic service,
  input  wire logic halt_req,
  input  wire logic dev_reset,
  input  wire logic pc_sp_reset,
  output logic      clear_watchdog_instr,
  output logic      halt_instr,
  output logic      low_power_mode
);
  int kick_cnt_r;

  // The kick period is 100 ticks, well inside the shortest time-out.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kick_cnt_r           <= 0;
      clear_watchdog_instr <= 1'b0;
    end else if (service) begin
      kick_cnt_r           <= (kick_cnt_r == KICK_CYC - 1) ? 0 : kick_cnt_r + 1;
      clear_watchdog_instr <= (kick_cnt_r == KICK_CYC - 1);
    end else begin
      clear_watchdog_instr <= 1'b0;
    end
  end

  // A halted core issues no further halt until a wake-up reset; kicks still follow service.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_instr     <= 1'b0;
      low_power_mode <= 1'b0;
    end else if (halt_req && !low_power_mode) begin
      halt_instr     <= 1'b1;
      low_power_mode <= 1'b1;
    end else begin
      halt_instr <= 1'b0;
      if (dev_reset || pc_sp_reset) low_power_mode <= 1'b0;
    end
  end
endmodule

// file: bench/tb_wdg_top.sv
`timescale 1ns/1ps
`include "wdg_regs.svh"
// ============================================================
// Register-level tests of the watchdog through the APB port.
module tb_wdg_top;
  localparam int SRST = 8;
  logic        clk, rst_n, psel, penable, pwrite, osc, osc_run, pin_n, service, halt_req, e;
  logic        pready, pslverr, clr_i, halt_i, lpm, dev_reset, pc_sp_reset, pc_clear;
  logic        port_preset, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          err_count, checks, cyc, since_clr, hit, tmo;

  wdg_top #(.SRESET_CYC(SRST)) u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_internal_osc(osc),
    .external_reset_pin_n(pin_n), .clear_watchdog_instr(clr_i), .halt_instr(halt_i),
    .low_power_mode(lpm), .dev_reset(dev_reset), .pc_sp_reset(pc_sp_reset),
    .pc_clear(pc_clear), .port_preset(port_preset), .irq(irq));
  wdg_cpu_model #(.KICK_CYC(400)) u_cpu (.clk(clk), .rst_n(rst_n), .service(service),
    .halt_req(halt_req), .dev_reset(dev_reset), .pc_sp_reset(pc_sp_reset),
    .clear_watchdog_instr(clr_i), .halt_instr(halt_i), .low_power_mode(lpm));

  // System clock 20 MHz; the slow oscillator ticks every 4 cycles, phase unrelated.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    osc = 1'b0;
    #37;
    forever begin
      #100;
      if (osc_run) osc = ~osc;
    end
  end

  // Cycles since the last clear or halt, and the hang limit; the tests need about 29000.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    since_clr <= (clr_i === 1'b1 || halt_i === 1'b1) ? 0 : since_clr + 1;
    if (cyc == 60000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_evt(input int lim);
    hit = 0;
    for (int i = 0; i < lim && hit == 0; i++) begin
      @(posedge clk);
      if (dev_reset === 1'b1 || pc_sp_reset === 1'b1) hit = 1;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, service, halt_req} = '0;
    {osc_run, pin_n} = 2'b11;
    {err_count, checks, cyc, since_clr} = '0;
    // Reset stays low for five edges and is released after the fifth.
    repeat (4) @(posedge clk);
    #1;
    chk(port_preset, 1);
    chk(pc_clear, 1);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(port_preset, 0);
    chk(pc_clear, 0);
    apb(0, `WDG_OFS_CTRL, 0);
    chk(r, 32'h53);
    apb(0, `WDG_OFS_STATUS, 0);
    chk(r, 32'h4);
    apb(0, `WDG_OFS_FLAGS, 0);
    chk(r, 0);
    apb(0, `WDG_OFS_PIN_CTRL, 0);
    chk(r, 32'h55);
    apb(0, 8'h40, 0);
    chk({r[30:0], e}, 1);
    apb(1, `WDG_OFS_IRQ_MASK, 0);
    // Kicked in time nothing happens; left alone it overflows after 2^N ticks.
    for (int s = 0; s < 3; s++) begin
      tmo = 4 << (8 + 2 * s);
      apb(1, `WDG_OFS_CTRL, {24'h0, `WDG_KEY_ENABLE, 3'(s)});
      service <= 1'b1;
      wait_evt(1500);
      chk(hit, 0);
      service <= 1'b0;
      wait_evt(tmo + 500);
      chk(dev_reset, 1);
      chk(since_clr > tmo - 7 && since_clr < tmo + 7, 1);
      apb(0, `WDG_OFS_STATUS, 0);
      chk(r & 1, 1);
    end
    #1;
    chk(irq, 0);
    apb(1, `WDG_OFS_IRQ_MASK, 1);
    #1;
    chk(irq, 1);
    apb(1, `WDG_OFS_IRQ_STAT, 1);
    #1;
    chk(irq, 0);
    // Overflow while halted only restarts the core.
    apb(1, `WDG_OFS_CTRL, 32'h50);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    wait_evt(1500);
    chk({dev_reset, pc_sp_reset}, 1);
    chk(since_clr > 1017 && since_clr < 1031, 1);
    apb(0, `WDG_OFS_STATUS, 0);
    chk(r & 3, 3);
    service <= 1'b1;
    repeat (420) @(posedge clk);
    service <= 0;
    apb(0, `WDG_OFS_STATUS, 0);
    chk(r & 3, 0);
    // Disabled, then halted: the counter is cleared and stays stopped.
    apb(1, `WDG_OFS_CTRL, 32'hA8);
    apb(0, `WDG_OFS_STATUS, 0);
    chk(r & 4, 0);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    osc_run = 1'b0;
    wait_evt(300);
    osc_run = 1'b1;
    wait_evt(1500);
    chk(hit, 0);
    apb(0, `WDG_OFS_COUNT, 0);
    chk(r, 0);
    // A bad key resets after the delay and leaves a sticky flag.
    apb(1, `WDG_OFS_CTRL, 32'hF8);
    apb(0, `WDG_OFS_STATUS, 0);
    chk(r & 8, 8);
    wait_evt(SRST + 20);
    chk(dev_reset, 1);
    apb(0, `WDG_OFS_CTRL, 0);
    chk(r, 32'h53);
    apb(1, `WDG_OFS_FLAGS, 1);
    apb(0, `WDG_OFS_FLAGS, 0);
    chk(r, 1);
    apb(1, `WDG_OFS_FLAGS, 0);
    apb(0, `WDG_OFS_FLAGS, 0);
    chk(r, 0);
    apb(0, `WDG_OFS_IRQ_STAT, 0);
    chk(r & 2, 2);
    // The pin resets only while selected, and holds the counter clear while low.
    pin_n <= 1'b0;
    wait_evt(20);
    chk(hit, 0);
    pin_n <= 1'b1;
    apb(1, `WDG_OFS_PIN_CTRL, 32'hAA);
    pin_n <= 1'b0;
    wait_evt(10);
    chk(dev_reset, 1);
    apb(0, `WDG_OFS_COUNT, 0);
    chk(r, 0);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    complete_run();
  end
endmodule
